/* File: adc_pm_pkg.sv */
package adc_pm_pkg;
	// power policies held in the two mode bits
	typedef enum logic [1:0] {
		SELECT_DRIVEN_POWERDOWN = 2'h0,
		ALWAYS_POWERED = 2'h1,
		AUTO_SHUTDOWN = 2'h2,
		AUTO_STANDBY = 2'h3
	} pm_mode_t;

	// control register field positions (msb first on the serial input)
	localparam int CTRL_W = 8;
	localparam int PM_LOW_POS = 0;
	localparam int PM_HIGH_POS = 1;
	localparam int REF_OFF_POS = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// frame timing in serial-clock edges
	localparam logic [4:0] FRAME_EDGES = 5'h10;
	localparam logic [4:0] SAMPLE_EDGE = 5'h02;
	localparam logic [4:0] CTRL_EDGES = 5'h08;
	localparam logic [4:0] CNT_RESET = 5'h00;

	// power-up delays
	localparam int CLK_MHZ = 25;
	localparam int COLD_UP_US = 5;
	localparam int WARM_UP_US = 1;
	localparam int COLD_UP_CYC = COLD_UP_US * CLK_MHZ;
	localparam int WARM_UP_CYC = WARM_UP_US * CLK_MHZ;
	localparam logic [7:0] DLY_RESET = 8'h00;

	localparam int FIFO_W = 16;
	localparam int FIFO_D = 8;

	// result word handed downstream
	typedef struct packed {
		logic [1:0] mode;
		logic valid;
		logic [12:0] sample_tag;
	} result_t;

	// enables toward the analog core
	typedef struct packed {
		logic core_on;
		logic ref_on;
		logic ready;
	} power_t;
endpackage : adc_pm_pkg

/* File: adc_power_mode_sequencer.sv */
`timescale 1ns/1ps
module adc_power_mode_sequencer
	import adc_pm_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic din_i,
	input wire logic result_ready_i,
	output logic [1:0] power_mode_o,
	output logic control_bit_five_o,
	output logic core_on_o,
	output logic ref_on_o,
	output logic ready_o,
	output logic track_o,
	output logic converting_o,
	output logic [FIFO_W-1:0] result_o,
	output logic result_valid_o
);
	typedef enum logic [1:0] {PWR_OFF, PWR_WAKE, PWR_ON} pwr_t;

	// two-stage synchronisers for the pins
	logic [1:0] sclk_s, cs_s, din_s;
	logic sclk_d, cs_d;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_s <= 2'h0;
			cs_s <= 2'h3;
			din_s <= 2'h0;
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			sclk_s <= {sclk_s[0], sclk_i};
			cs_s <= {cs_s[0], cs_n_i};
			din_s <= {din_s[0], din_i};
			sclk_d <= sclk_s[1];
			cs_d <= cs_s[1];
		end
	end

	logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_low;
	assign sclk_rise = sclk_s[1] && !sclk_d;
	assign sclk_fall = !sclk_s[1] && sclk_d;
	assign cs_fall = !cs_s[1] && cs_d;
	assign cs_rise = cs_s[1] && !cs_d;
	assign cs_low = !cs_s[1];

	// frame state
	logic [4:0] edge_r, edge_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic first_fall_r, first_fall_nxt;
	logic conv_r, conv_nxt;
	logic track_r, track_nxt;
	logic done_r, done_nxt;
	logic [11:0] frame_cnt_r, frame_cnt_nxt;
	pm_mode_t mode;
	logic auto_mode;
	assign mode = pm_mode_t'({ctrl_r[PM_HIGH_POS], ctrl_r[PM_LOW_POS]});
	assign auto_mode = (mode == AUTO_SHUTDOWN) || (mode == AUTO_STANDBY);

	// frame counter, control shift-in and conversion tracking
	always_comb begin
		edge_nxt = edge_r;
		shift_nxt = shift_r;
		ctrl_nxt = ctrl_r;
		first_fall_nxt = first_fall_r;
		conv_nxt = conv_r;
		track_nxt = track_r;
		done_nxt = 1'b0;
		frame_cnt_nxt = frame_cnt_r;
		if (cs_fall) begin
			edge_nxt = CNT_RESET;
			first_fall_nxt = 1'b1;
			track_nxt = 1'b1;
			conv_nxt = 1'b0;
		end else if (cs_rise) begin
			track_nxt = 1'b0;
			conv_nxt = 1'b0;
			first_fall_nxt = 1'b0;
		end else if (cs_low) begin
			if (sclk_fall) begin
				first_fall_nxt = 1'b0;
			end
			if (sclk_rise && edge_r < FRAME_EDGES) begin
				edge_nxt = edge_r + 5'h01;
				if (edge_r < CTRL_EDGES) begin
					shift_nxt = {shift_r[6:0], din_s[1]};
				end
				if (edge_r + 5'h01 == CTRL_EDGES) begin
					ctrl_nxt = {shift_r[6:0], din_s[1]};
				end
				if (edge_r + 5'h01 == SAMPLE_EDGE) begin
					track_nxt = 1'b0;
					conv_nxt = 1'b1;
				end
				if (edge_r + 5'h01 == FRAME_EDGES) begin
					conv_nxt = 1'b0;
					done_nxt = 1'b1;
					frame_cnt_nxt = frame_cnt_r + 12'h001;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			edge_r <= CNT_RESET;
			shift_r <= CTRL_RESET;
			ctrl_r <= CTRL_RESET;
			first_fall_r <= 1'b0;
			conv_r <= 1'b0;
			track_r <= 1'b0;
			done_r <= 1'b0;
			frame_cnt_r <= 12'h000;
		end else begin
			edge_r <= edge_nxt;
			shift_r <= shift_nxt;
			ctrl_r <= ctrl_nxt;
			first_fall_r <= first_fall_nxt;
			conv_r <= conv_nxt;
			track_r <= track_nxt;
			done_r <= done_nxt;
			frame_cnt_r <= frame_cnt_nxt;
		end
	end

	// power sequencing
	pwr_t pwr_r, pwr_nxt;
	logic [7:0] dly_r, dly_nxt;
	logic stby_r, stby_nxt;
	logic wake_ev, down_ev;
	logic [7:0] wake_len;
	always_comb begin
		wake_ev = 1'b0;
		down_ev = 1'b0;
		unique case (mode)
			SELECT_DRIVEN_POWERDOWN: begin
				wake_ev = cs_fall;
				down_ev = cs_rise;
			end
			ALWAYS_POWERED: begin
				wake_ev = (pwr_r == PWR_OFF);
			end
			AUTO_SHUTDOWN, AUTO_STANDBY: begin
				wake_ev = cs_low && sclk_fall && first_fall_r;
				down_ev = cs_low && sclk_rise && (edge_r + 5'h01 == FRAME_EDGES);
			end
		endcase
		// short wake from standby or with reference off
		if (stby_r || ctrl_r[REF_OFF_POS]) begin
			wake_len = 8'(WARM_UP_CYC);
		end else begin
			wake_len = 8'(COLD_UP_CYC);
		end
		pwr_nxt = pwr_r;
		dly_nxt = dly_r;
		stby_nxt = stby_r;
		if (mode == ALWAYS_POWERED && pwr_r == PWR_WAKE) begin
			pwr_nxt = PWR_ON;
			dly_nxt = DLY_RESET;
		end else if (down_ev) begin
			pwr_nxt = PWR_OFF;
			stby_nxt = (mode == AUTO_STANDBY);
		end else if (wake_ev && pwr_r == PWR_OFF) begin
			pwr_nxt = (mode == ALWAYS_POWERED) ? PWR_ON : PWR_WAKE;
			dly_nxt = wake_len;
		end else if (pwr_r == PWR_WAKE) begin
			if (dly_r <= 8'h01) begin
				pwr_nxt = PWR_ON;
				dly_nxt = DLY_RESET;
				stby_nxt = 1'b0;
			end else begin
				dly_nxt = dly_r - 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwr_r <= PWR_OFF;
			dly_r <= DLY_RESET;
			stby_r <= 1'b0;
		end else begin
			pwr_r <= pwr_nxt;
			dly_r <= dly_nxt;
			stby_r <= stby_nxt;
		end
	end

	// registered outputs toward the analog core
	power_t pwr_out;
	always_comb begin
		pwr_out.core_on = (pwr_r != PWR_OFF);
		pwr_out.ref_on = !ctrl_r[REF_OFF_POS] && ((pwr_r != PWR_OFF) || stby_r);
		pwr_out.ready = (pwr_r == PWR_ON);
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			power_mode_o <= 2'h0;
			control_bit_five_o <= 1'b0;
			core_on_o <= 1'b0;
			ref_on_o <= 1'b0;
			ready_o <= 1'b0;
			track_o <= 1'b0;
			converting_o <= 1'b0;
		end else begin
			power_mode_o <= mode;
			control_bit_five_o <= ctrl_r[REF_OFF_POS];
			core_on_o <= pwr_out.core_on;
			ref_on_o <= pwr_out.ref_on;
			ready_o <= pwr_out.ready;
			track_o <= track_r;
			converting_o <= conv_r && (pwr_r != PWR_OFF);
		end
	end

	// completed frames queue up for the consumer
	result_t res_in;
	logic [FIFO_W-1:0] fifo_q;
	logic fifo_v;
	logic valid_at_sample_r;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			valid_at_sample_r <= 1'b0;
		end else if (cs_low && sclk_rise && edge_r + 5'h01 == SAMPLE_EDGE) begin
			valid_at_sample_r <= (pwr_r == PWR_ON);
		end
	end
	always_comb begin
		res_in.mode = mode;
		res_in.valid = valid_at_sample_r;
		res_in.sample_tag = {1'b0, frame_cnt_r};
	end

	result_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.in_data_i(res_in),
		.in_valid_i(done_r),
		.in_ready_o(),
		.out_data_o(fifo_q),
		.out_valid_o(fifo_v),
		.out_ready_i(result_ready_i && !result_valid_o)
	);

	// output stage register: holds a word until taken
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			result_o <= 16'h0000;
			result_valid_o <= 1'b0;
		end else if (result_valid_o && result_ready_i) begin
			result_valid_o <= 1'b0;
		end else if (!result_valid_o && fifo_v && result_ready_i) begin
			result_o <= fifo_q;
			result_valid_o <= 1'b1;
		end
	end

	// assertions
	sequence frame_done_s;
		cs_low && sclk_rise && edge_r == 5'h0F;
	endsequence
	auto_down_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		frame_done_s and auto_mode |=> pwr_r == PWR_OFF) else $error("auto mode not down");
	auto_wake_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		auto_mode && wake_ev && pwr_r == PWR_OFF |=> pwr_r == PWR_WAKE)
		else $error("auto wake missed");
	cs_down_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		mode == SELECT_DRIVEN_POWERDOWN && cs_rise |=> pwr_r == PWR_OFF && !conv_r)
		else $error("select rise kept power");
	always_on_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		mode == ALWAYS_POWERED && $stable(mode) |=> ##1 pwr_r == PWR_ON)
		else $error("always mode not on");
	cold_delay_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(pwr_r == PWR_WAKE) && dly_r == 8'(COLD_UP_CYC)
		|-> ##[120:124] (pwr_r != PWR_ON || mode == ALWAYS_POWERED))
		else $error("cold delay short");
	warm_delay_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		$rose(pwr_r == PWR_WAKE) && dly_r == 8'(WARM_UP_CYC) && mode != ALWAYS_POWERED
		&& !down_ev |-> ##[1:30] pwr_r != PWR_WAKE) else $error("warm delay long");
	sample_edge_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		cs_low && sclk_rise && edge_r == 5'h01 |=> !track_r && conv_r)
		else $error("sample edge wrong");
	ctrl_load_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		cs_low && sclk_rise && edge_r == 5'h07 |=> ctrl_r == $past(ctrl_nxt))
		else $error("control not loaded");
	ref_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
		ctrl_r[REF_OFF_POS] |=> !ref_on_o) else $error("reference on while disabled");
endmodule : adc_power_mode_sequencer

/* File: host_link_model.sv */
`timescale 1ns/1ps
module host_link_model (
	input wire logic ref_clk_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic din_o
);
	// idle link: select high, serial clock parked high
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
		din_o = 1'b0;
	end

	// wait a number of falling system-clock edges
	task automatic pause(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : pause

	// one transfer, config msb first; gap holds off the sampling edge; fewer edges aborts
	// an all-zero config is a read-only host: din stays low for the whole transfer
	task automatic frame(input logic [7:0] cfg, input int gap, input int edges);
		cs_n_o = 1'b0;
		pause(8);
		for (int i = 0; i < edges; i++) begin
			sclk_o = 1'b0;
			din_o = (i < 8) ? cfg[7 - i] : (|cfg && !din_o);
			if (i == 0) begin
				pause(gap);
			end
			pause(4);
			sclk_o = 1'b1;
			pause(4);
		end
		cs_n_o = 1'b1;
		din_o = |cfg && !din_o;
		pause(2);
	endtask : frame
endmodule : host_link_model

/* File: result_fifo.sv */
`timescale 1ns/1ps
module result_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	// honest full and empty from the occupancy count
	always_comb begin
		in_ready_o = (cnt_r != (AW+1)'(D));
		out_valid_o = (cnt_r != '0);
		out_data_o = mem[rd_r];
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	// pointers and count
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage, no reset needed
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem[wr_r] <= in_data_i;
		end
	end
endmodule : result_fifo

/* File: test_adc_power_mode_sequencer.sv */
`timescale 1ns/1ps
module test_adc_power_mode_sequencer;
	import adc_pm_pkg::*;
	logic ref_clk_i, resetn_i, cs_n, sclk, din, result_ready_i, rb;
	logic [1:0] power_mode_o;
	logic control_bit_five_o, core_on_o, ref_on_o, ready_o, track_o, converting_o;
	logic [FIFO_W-1:0] result_o, last_word;
	logic result_valid_o;
	int mismatches = 0, tests_run = 0, cnt, seed = 32'h9334;
	pm_mode_t seq[4] = '{ALWAYS_POWERED, AUTO_SHUTDOWN, AUTO_STANDBY, SELECT_DRIVEN_POWERDOWN};

	adc_power_mode_sequencer i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .din_i(din), .result_ready_i(result_ready_i),
		.power_mode_o(power_mode_o), .control_bit_five_o(control_bit_five_o),
		.core_on_o(core_on_o), .ref_on_o(ref_on_o), .ready_o(ready_o), .track_o(track_o),
		.converting_o(converting_o), .result_o(result_o), .result_valid_o(result_valid_o));
	host_link_model i_host (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));

	// system clock
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	task automatic pause(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : pause

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	// drain results with a randomly stalling consumer; cnt words, last one kept
	task automatic flush();
		int idle;
		logic go;
		cnt = 0;
		idle = 0;
		while (idle < 20) begin
			@(negedge ref_clk_i);
			idle++;
			// ready may rise before valid: the output stage only loads while ready is high
			go = 1'($random(seed));
			result_ready_i = go;
			if (go && result_valid_o === 1'b1) begin
				cnt++;
				last_word = result_o;
				idle = 0;
			end
		end
		result_ready_i = 1'b0;
	endtask : flush

	// full transfer writing mode m, random spare bits
	task automatic send(input pm_mode_t m, input logic refb, input int gap);
		logic [7:0] cfg;
		cfg = 8'($random(seed));
		cfg[1:0] = m;
		cfg[5] = refb;
		i_host.frame(cfg, gap, 16);
		pause(8);
	endtask : send

	// wake in an auto mode and time the power-up delay
	task automatic wake(input pm_mode_t m, input int up);
		int n;
		n = 0;
		fork
			send(m, 1'b0, COLD_UP_CYC + 20);
			begin
				pause(8);
				check(core_on_o, 1'b0);
				check(track_o, 1'b1);
				while (core_on_o !== 1'b1 && n < 300) begin
					pause(1);
					n++;
				end
				n = 0;
				while (ready_o !== 1'b1 && n < 300) begin
					pause(1);
					n++;
				end
				check(n >= up - 2 && n <= up + 4, 1'b1);
				n = 0;
				while (converting_o !== 1'b1 && n < 300) begin
					pause(1);
					n++;
				end
				check(converting_o, 1'b1);
				check(track_o, 1'b0);
			end
		join
		flush();
	endtask : wake

	// main sequence
	initial begin
		resetn_i = 1'b0;
		result_ready_i = 1'b0;
		last_word = '0;
		pause(2);
		resetn_i = 1'b1;
		pause(2);
		check(power_mode_o, SELECT_DRIVEN_POWERDOWN);
		for (int i = 0; i < 4; i++) begin
			rb = (i == 2) ? 1'b0 : 1'($random(seed));
			send(seq[i], rb, COLD_UP_CYC + 20);
			check(power_mode_o, seq[i]);
			check(control_bit_five_o, rb);
			check(core_on_o, seq[i] == ALWAYS_POWERED);
			if (i == 2) begin
				check(ref_on_o, 1'b1);
			end
			flush();
			check(cnt, 1);
			check(last_word[13], 1'b1);
			check(last_word[15:14], seq[i]);
			check(last_word[12:0], i + 1);
		end
		send(AUTO_SHUTDOWN, 1'b0, 0);
		flush();
		check(last_word[13], 1'b0);
		wake(AUTO_SHUTDOWN, COLD_UP_CYC);
		send(AUTO_STANDBY, 1'b0, 0);
		flush();
		wake(AUTO_STANDBY, WARM_UP_CYC);
		send(ALWAYS_POWERED, 1'b0, 0);
		flush();
		send(SELECT_DRIVEN_POWERDOWN, 1'b0, 0);
		flush();
		check(last_word[13], 1'b1);
		i_host.frame(8'h00, 0, 5);
		pause(8);
		check(converting_o, 1'b0);
		check(core_on_o, 1'b0);
		flush();
		repeat (FIFO_D + 2) i_host.frame(8'h01, 0, 16);
		pause(8);
		flush();
		check(cnt, FIFO_D);
		summarize();
	end

	// watchdog: several times the expected run of 21 frames
	initial begin
		#2_000_000;
		mismatches++;
		summarize();
	end
endmodule : test_adc_power_mode_sequencer
